//--- shared/motion_pkg.sv
// Shared constants for the motion wake and sleep detector
package motion_pkg;
    // ==========================================================
    // Widths
    localparam int SAMPLE_W = 16;
    localparam int THRESH_W = 12;
    localparam int COUNT_W = 8;
    localparam int RATE_SEL_W = 3;
    localparam int DIFF_W = SAMPLE_W + 1;
    // ==========================================================
    // Threshold scale, counts per g
    localparam int COUNTS_PER_G = 256;
    // Shift taking a sample of SAMPLE_W bits to 256 counts per g
    localparam int SCALE_SHIFT = 4;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CONTROL_REG_THREE_OFS = 8'h00;
    localparam logic [7:0] CONTROL_REG_FOUR_OFS = 8'h04;
    localparam logic [7:0] WAKE_THRESHOLD_OFS = 8'h08;
    localparam logic [7:0] SLEEP_THRESHOLD_OFS = 8'h0C;
    localparam logic [7:0] WAKE_COUNT_OFS = 8'h10;
    localparam logic [7:0] SLEEP_COUNT_OFS = 8'h14;
    localparam logic [7:0] STATE_OFS = 8'h18;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h1C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
    // ==========================================================
    // Field positions and reset values
    localparam int RATE_SEL_LSB = 0;
    localparam int IRQ_MOTION_BIT = 0;
    localparam int IRQ_NO_MOTION_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [RATE_SEL_W-1:0] RATE_SEL_RESET = 3'h0;
    localparam logic [THRESH_W-1:0] THRESH_RESET = 12'h000;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // ==========================================================
    // Engine states, Gray coded along idle -> count -> idle
    typedef enum logic [1:0] {
        EVAL_IDLE = 2'b00,
        EVAL_COUNT = 2'b01
    } eval_state_e;
endpackage

//--- logic/rate_strobe_pick.sv
// Picks one sample-rate strobe from a set by a select field
`timescale 1ns/1ns
`default_nettype none
module rate_strobe_pick #(
    parameter int RATES = 8
) (
    input wire logic [RATES-1:0] rate_strobes,
    input wire logic [motion_pkg::RATE_SEL_W-1:0] rate_sel,
    output logic strobe
);
    import motion_pkg::*;
    assign strobe = rate_strobes[rate_sel];
endmodule
`default_nettype wire

//--- logic/debounce_engine.sv
// Reference-latched debounce counter for one direction of change
`timescale 1ns/1ns
`default_nettype none
module debounce_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic strobe,
    input wire logic want_above,
    input wire logic [motion_pkg::SAMPLE_W-1:0] sample_x,
    input wire logic [motion_pkg::SAMPLE_W-1:0] sample_y,
    input wire logic [motion_pkg::SAMPLE_W-1:0] sample_z,
    input wire logic [motion_pkg::SAMPLE_W-1:0] prev_x,
    input wire logic [motion_pkg::SAMPLE_W-1:0] prev_y,
    input wire logic [motion_pkg::SAMPLE_W-1:0] prev_z,
    input wire logic [motion_pkg::THRESH_W-1:0] threshold,
    input wire logic [motion_pkg::COUNT_W-1:0] count_target,
    output logic done
);
    import motion_pkg::*;

    eval_state_e state_q;
    logic [COUNT_W-1:0] count_q;
    logic [SAMPLE_W-1:0] ref_x_q, ref_y_q, ref_z_q;
    logic hit;

    // ==========================================================
    // Magnitude of a difference, scaled to 256 counts per g
    function automatic logic [DIFF_W-1:0] mag(
        input logic [SAMPLE_W-1:0] a,
        input logic [SAMPLE_W-1:0] b
    );
        logic signed [DIFF_W-1:0] d;
        d = DIFF_W'(signed'(a)) - DIFF_W'(signed'(b));
        if (d < 0) begin
            d = -d;
        end
        return DIFF_W'(d) >> SCALE_SHIFT;
    endfunction

    function automatic logic over(
        input logic [DIFF_W-1:0] m,
        input logic [THRESH_W-1:0] t
    );
        return m > DIFF_W'(t);
    endfunction

    // ==========================================================
    // Compare against previous sample when idle, reference when counting
    logic [SAMPLE_W-1:0] bx, by, bz;
    logic any_over, any_under;
    always_comb begin
        bx = (state_q == EVAL_COUNT) ? ref_x_q : prev_x;
        by = (state_q == EVAL_COUNT) ? ref_y_q : prev_y;
        bz = (state_q == EVAL_COUNT) ? ref_z_q : prev_z;
        any_over = over(mag(sample_x, bx), threshold) |
                   over(mag(sample_y, by), threshold) |
                   over(mag(sample_z, bz), threshold);
        // Below means every axis at or under the sleep level
        any_under = !any_over;
        hit = want_above ? any_over : any_under;
    end

    // ==========================================================
    // Count one unit per selected-rate strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= EVAL_IDLE;
            count_q <= COUNT_RESET;
            ref_x_q <= '0;
            ref_y_q <= '0;
            ref_z_q <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!enable) begin
                state_q <= EVAL_IDLE;
                count_q <= COUNT_RESET;
            end else if (strobe) begin
                case (state_q)
                    EVAL_IDLE: begin
                        if (hit) begin
                            ref_x_q <= prev_x;
                            ref_y_q <= prev_y;
                            ref_z_q <= prev_z;
                            count_q <= COUNT_RESET;
                            if (count_target == COUNT_RESET) begin
                                done <= 1'b1;
                            end else begin
                                state_q <= EVAL_COUNT;
                            end
                        end
                    end
                    EVAL_COUNT: begin
                        if (!hit) begin
                            state_q <= EVAL_IDLE;
                        end else if (count_q + 8'h01 >= count_target) begin
                            done <= 1'b1;
                            state_q <= EVAL_IDLE;
                        end else begin
                            count_q <= count_q + 8'h01;
                        end
                    end
                    default: begin
                        state_q <= EVAL_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/motion_wake_sleep_detector.sv
// Motion wake and back-to-sleep detector with APB registers
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Inactive becomes active when any axis difference exceeds the wake threshold.
// - Active becomes inactive when the difference falls below the sleep threshold.
// - Both thresholds are read at 256 counts per g.
// - Detection ignores measurement range and resolution settings.
// - Each debounce count is an 8-bit unsigned software value.
// - A wake count unit is one period of the rate picked in control reg three.
// - A sleep count unit is one period of the rate picked in control reg four.
// - While inactive each sample is differenced with the previous sample.
// - A difference above the wake threshold starts the wake count.
// - During a count the difference is taken against the latched reference.
// - A wake count kept above threshold to its end gives motion and active.
// - A drop below the wake threshold aborts the count, staying inactive.
// - While active a difference below sleep threshold starts the sleep count.
// - A sleep count kept below threshold to its end gives no-motion.
// - A rise above the sleep threshold halts the count, staying active.
module motion_wake_sleep_detector #(
    parameter int RATES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [motion_pkg::SAMPLE_W-1:0] sample_x,
    input wire logic [motion_pkg::SAMPLE_W-1:0] sample_y,
    input wire logic [motion_pkg::SAMPLE_W-1:0] sample_z,
    input wire logic [RATES-1:0] rate_strobes,
    output logic active,
    output logic motion_event,
    output logic no_motion_event,
    output logic irq
);
    import motion_pkg::*;

    // ==========================================================
    // Registers
    logic [RATE_SEL_W-1:0] wake_rate_select_q, sleep_rate_select_q;
    logic [THRESH_W-1:0] wake_threshold_q, sleep_threshold_q;
    logic [COUNT_W-1:0] wake_debounce_count_q, sleep_debounce_count_q;
    logic [IRQ_W-1:0] irq_status_q, irq_mask_q;
    logic active_q;
    logic [SAMPLE_W-1:0] prev_x_q, prev_y_q, prev_z_q;

    logic wr_en, rd_en;
    logic wake_strobe_raw, sleep_strobe_raw;
    logic wake_strobe, sleep_strobe;
    logic wake_done, sleep_done;
    logic [IRQ_W-1:0] irq_set;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & !pwrite;

    // ==========================================================
    // Configuration writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_rate_select_q <= RATE_SEL_RESET;
            sleep_rate_select_q <= RATE_SEL_RESET;
            wake_threshold_q <= THRESH_RESET;
            sleep_threshold_q <= THRESH_RESET;
            wake_debounce_count_q <= COUNT_RESET;
            sleep_debounce_count_q <= COUNT_RESET;
            irq_mask_q <= IRQ_MASK_RESET;
        end else if (wr_en) begin
            case (paddr)
                CONTROL_REG_THREE_OFS: begin
                    wake_rate_select_q <=
                        pwdata[RATE_SEL_LSB +: RATE_SEL_W];
                end
                CONTROL_REG_FOUR_OFS: begin
                    sleep_rate_select_q <=
                        pwdata[RATE_SEL_LSB +: RATE_SEL_W];
                end
                WAKE_THRESHOLD_OFS: begin
                    wake_threshold_q <= pwdata[THRESH_W-1:0];
                end
                SLEEP_THRESHOLD_OFS: begin
                    sleep_threshold_q <= pwdata[THRESH_W-1:0];
                end
                WAKE_COUNT_OFS: begin
                    wake_debounce_count_q <= pwdata[COUNT_W-1:0];
                end
                SLEEP_COUNT_OFS: begin
                    sleep_debounce_count_q <= pwdata[COUNT_W-1:0];
                end
                IRQ_MASK_OFS: begin
                    irq_mask_q <= pwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Read mux; unmapped addresses read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= UNMAPPED_READ;
        end else if (psel & !penable & !pwrite) begin
            case (paddr)
                CONTROL_REG_THREE_OFS: prdata <= 32'(wake_rate_select_q);
                CONTROL_REG_FOUR_OFS: prdata <= 32'(sleep_rate_select_q);
                WAKE_THRESHOLD_OFS: prdata <= 32'(wake_threshold_q);
                SLEEP_THRESHOLD_OFS: prdata <= 32'(sleep_threshold_q);
                WAKE_COUNT_OFS: prdata <= 32'(wake_debounce_count_q);
                SLEEP_COUNT_OFS: prdata <= 32'(sleep_debounce_count_q);
                STATE_OFS: prdata <= 32'(active_q);
                IRQ_STATUS_OFS: prdata <= 32'(irq_status_q);
                IRQ_MASK_OFS: prdata <= 32'(irq_mask_q);
                default: prdata <= UNMAPPED_READ;
            endcase
        end
    end

    // ==========================================================
    // Rate strobes, gated by a fresh sample
    rate_strobe_pick #(.RATES(RATES)) u_wake_pick (
        .rate_strobes(rate_strobes),
        .rate_sel(wake_rate_select_q),
        .strobe(wake_strobe_raw)
    );
    rate_strobe_pick #(.RATES(RATES)) u_sleep_pick (
        .rate_strobes(rate_strobes),
        .rate_sel(sleep_rate_select_q),
        .strobe(sleep_strobe_raw)
    );
    assign wake_strobe = wake_strobe_raw & sample_valid;
    assign sleep_strobe = sleep_strobe_raw & sample_valid;

    // ==========================================================
    // Previous sample; samples arrive already range-normalised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_x_q <= '0;
            prev_y_q <= '0;
            prev_z_q <= '0;
        end else if (sample_valid) begin
            prev_x_q <= sample_x;
            prev_y_q <= sample_y;
            prev_z_q <= sample_z;
        end
    end

    // ==========================================================
    // Engines; only one runs, chosen by current state
    debounce_engine u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .enable(!active_q),
        .strobe(wake_strobe),
        .want_above(1'b1),
        .sample_x(sample_x),
        .sample_y(sample_y),
        .sample_z(sample_z),
        .prev_x(prev_x_q),
        .prev_y(prev_y_q),
        .prev_z(prev_z_q),
        .threshold(wake_threshold_q),
        .count_target(wake_debounce_count_q),
        .done(wake_done)
    );
    debounce_engine u_sleep (
        .pclk(pclk),
        .presetn(presetn),
        .enable(active_q),
        .strobe(sleep_strobe),
        .want_above(1'b0),
        .sample_x(sample_x),
        .sample_y(sample_y),
        .sample_z(sample_z),
        .prev_x(prev_x_q),
        .prev_y(prev_y_q),
        .prev_z(prev_z_q),
        .threshold(sleep_threshold_q),
        .count_target(sleep_debounce_count_q),
        .done(sleep_done)
    );

    // ==========================================================
    // Activity state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
        end else if (!active_q && wake_done) begin
            active_q <= 1'b1;
        end else if (active_q && sleep_done) begin
            active_q <= 1'b0;
        end
    end

    // ==========================================================
    // Event pulses and sticky status; set wins over read clear
    assign irq_set = {active_q & sleep_done, !active_q & wake_done};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motion_event <= 1'b0;
            no_motion_event <= 1'b0;
            irq_status_q <= '0;
        end else begin
            motion_event <= irq_set[IRQ_MOTION_BIT];
            no_motion_event <= irq_set[IRQ_NO_MOTION_BIT];
            // Clear only what the setup cycle captured, so late sets survive
            if (rd_en && paddr == IRQ_STATUS_OFS) begin
                irq_status_q <= (irq_status_q & ~prdata[IRQ_W-1:0]) |
                                irq_set;
            end else begin
                irq_status_q <= irq_status_q | irq_set;
            end
        end
    end

    assign active = active_q;
    assign irq = |(irq_status_q & irq_mask_q);
endmodule
`default_nettype wire

//--- verif/motion_checker_asserts.sv
// Concurrent port checks for the motion detector
`timescale 1ns/1ns
`default_nettype none
module motion_checker #(
    parameter int RATES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic sample_valid,
    input wire logic [RATES-1:0] rate_strobes,
    input wire logic active,
    input wire logic motion_event,
    input wire logic no_motion_event,
    input wire logic irq
);
    import motion_pkg::*;
    logic strobe_seen;
    assign strobe_seen = sample_valid && (|rate_strobes);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_event;
        motion_event || no_motion_event;
    endsequence
    sequence s_status_read;
        psel && penable && !pwrite && paddr == IRQ_STATUS_OFS;
    endsequence
    property p_wake_edge;
        $rose(active) |-> motion_event;
    endproperty
    a_wake_edge: assert property (p_wake_edge)
        else $error("active rose without motion event");
    property p_sleep_edge;
        $fell(active) |-> no_motion_event;
    endproperty
    a_sleep_edge: assert property (p_sleep_edge)
        else $error("active fell without no-motion event");
    property p_motion_state;
        motion_event |-> active && !$past(active);
    endproperty
    a_motion_state: assert property (p_motion_state)
        else $error("motion event outside inactive to active");
    property p_nomotion_state;
        no_motion_event |-> !active && $past(active);
    endproperty
    a_nomotion_state: assert property (p_nomotion_state)
        else $error("no-motion event outside active to inactive");
    property p_event_pulse;
        s_event |=> !motion_event && !no_motion_event;
    endproperty
    a_event_pulse: assert property (p_event_pulse)
        else $error("event flag longer than one cycle");
    // Done is one stage and the event two stages behind the strobe
    property p_event_cause;
        s_event |-> $past(strobe_seen) || $past(strobe_seen, 2);
    endproperty
    a_event_cause: assert property (p_event_cause)
        else $error("event without a selected rate strobe");
    property p_status_clear;
        // An event set at the setup edge is not in the read word
        s_status_read |=> !irq || motion_event || no_motion_event ||
            $past(motion_event || no_motion_event);
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("irq held after status read");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("access phase without ready");
endmodule
bind motion_wake_sleep_detector motion_checker #(.RATES(RATES))
    i_motion_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .sample_valid, .rate_strobes, .active, .motion_event,
    .no_motion_event, .irq
);
`default_nettype wire

//--- verif/sample_source.sv
// Filtered sample path model feeding the detector
`timescale 1ns/1ns
`default_nettype none
module sample_source (
    input wire logic pclk,
    output logic sample_valid,
    output logic [motion_pkg::SAMPLE_W-1:0] sample_x,
    output logic [motion_pkg::SAMPLE_W-1:0] sample_y,
    output logic [motion_pkg::SAMPLE_W-1:0] sample_z,
    output logic [7:0] rate_strobes
);
    import motion_pkg::*;
    initial begin
        sample_valid = 1'b0;
        sample_x = 16'hFFBF;
        sample_y = 16'hFFFF;
        sample_z = 16'hFFFF;
        rate_strobes = 8'h00;
    end
    // X and z held fixed so y alone decides each difference
    task automatic send(input logic [SAMPLE_W-1:0] y, input logic [7:0] s);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_x <= 16'h0040;
        sample_y <= y;
        sample_z <= 16'h0000;
        rate_strobes <= s;
        @(posedge pclk);
        sample_valid <= 1'b0;
        rate_strobes <= 8'h00;
        // Stale outside the valid cycle, inverted so nothing leaks
        sample_x <= 16'hFFBF;
        sample_y <= ~y;
        sample_z <= 16'hFFFF;
    endtask
endmodule
`default_nettype wire

//--- verif/motion_wake_sleep_detector_test.sv
// Self-checking bench for the motion wake and sleep detector
`timescale 1ns/1ns
`default_nettype none
module motion_wake_sleep_detector_test;
    import motion_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, sample_valid, active, motion_event;
    logic no_motion_event, irq;
    logic [SAMPLE_W-1:0] sample_x, sample_y, sample_z;
    logic [7:0] rate_strobes;
    int n_fail = 0;
    int n_checks = 0;
    int n_mot = 0;
    int n_nom = 0;
    always #5 pclk = ~pclk;
    motion_wake_sleep_detector i_motion_wake_sleep_detector (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sample_valid, .sample_x, .sample_y,
        .sample_z, .rate_strobes, .active, .motion_event,
        .no_motion_event, .irq
    );
    sample_source i_sample_source (
        .pclk, .sample_valid, .sample_x, .sample_y, .sample_z,
        .rate_strobes
    );
    always @(posedge pclk) begin
        if (motion_event === 1'b1) n_mot <= n_mot + 1;
        if (no_motion_event === 1'b1) n_nom <= n_nom + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // On a read, d is the expected word
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input string what);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 8; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (!wr) check(what, prdata, d);
        check("pslverr", pslverr, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 8) begin
            check("pready", 32'h0, 32'h1);
            test_done();
        end
    endtask
    task automatic tx(input logic [15:0] y, input logic [7:0] s);
        i_sample_source.send(y, s);
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_regs;
        apb(1'b0, CONTROL_REG_FOUR_OFS, 32'h0, "ctrl4 reset");
        apb(1'b0, IRQ_MASK_OFS, 32'h0, "mask reset");
        apb(1'b0, 8'h24, 32'h0, "unmapped");
        apb(1'b1, SLEEP_COUNT_OFS, 32'h1FF, "");
        apb(1'b0, SLEEP_COUNT_OFS, 32'hFF, "count width");
        apb(1'b1, STATE_OFS, 32'h1, "");
        apb(1'b0, STATE_OFS, 32'h0, "state read only");
        $display("test regs done");
    endtask
    task automatic t_rate;
        apb(1'b1, CONTROL_REG_THREE_OFS, 32'h3, "");
        apb(1'b1, WAKE_THRESHOLD_OFS, 32'h4, "");
        apb(1'b1, WAKE_COUNT_OFS, 32'h1, "");
        tx(16'h0000, 8'h08);
        tx(16'h0200, 8'hF7);
        tx(16'h0000, 8'hF7);
        check("motion off rate", n_mot, 0);
        tx(16'h0040, 8'h08);
        check("motion at threshold", n_mot, 0);
        tx(16'h0240, 8'h08);
        check("wake one unit", n_mot, 0);
        tx(16'h0240, 8'h08);
        check("motion count", n_mot, 1);
        check("active", active, 1);
        check("irq masked", irq, 0);
        apb(1'b1, IRQ_MASK_OFS, 32'h1, "");
        @(posedge pclk);
        check("irq unmasked", irq, 1);
        apb(1'b0, IRQ_STATUS_OFS, 32'h1, "status motion");
        @(posedge pclk);
        check("irq cleared", irq, 0);
        $display("test rate done");
    endtask
    // Drift small against the previous sample, large against reference
    task automatic t_sleep;
        apb(1'b1, CONTROL_REG_FOUR_OFS, 32'h5, "");
        apb(1'b1, SLEEP_THRESHOLD_OFS, 32'h4, "");
        apb(1'b1, SLEEP_COUNT_OFS, 32'h3, "");
        tx(16'h0240, 8'h20);
        tx(16'h0280, 8'h20);
        tx(16'h02C0, 8'h20);
        check("halted sleep", n_nom, 0);
        check("still active", active, 1);
        tx(16'h02C0, 8'h20);
        tx(16'h02C0, 8'h20);
        tx(16'h0300, 8'h20);
        check("early sleep", n_nom, 0);
        tx(16'h0300, 8'h20);
        check("sleep count", n_nom, 1);
        check("inactive", active, 0);
        $display("test sleep done");
    endtask
    task automatic t_wake;
        apb(1'b1, CONTROL_REG_THREE_OFS, 32'h0, "");
        apb(1'b1, WAKE_COUNT_OFS, 32'h3, "");
        tx(16'h0500, 8'h01);
        tx(16'h0300, 8'h01);
        check("aborted wake", n_mot, 1);
        tx(16'h0500, 8'h01);
        tx(16'h0500, 8'h01);
        tx(16'h0500, 8'h01);
        check("early wake", n_mot, 1);
        tx(16'h0500, 8'h01);
        check("wake count", n_mot, 2);
        check("active again", active, 1);
        apb(1'b1, IRQ_MASK_OFS, 32'h2, "");
        @(posedge pclk);
        check("irq sleep bit", irq, 1);
        apb(1'b0, IRQ_STATUS_OFS, 32'h3, "both events");
        apb(1'b0, IRQ_STATUS_OFS, 32'h0, "status cleared");
        check("irq low", irq, 0);
        $display("test wake done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rate();
        t_sleep();
        t_wake();
        test_done();
    end
endmodule
`default_nettype wire
